// >>> design/hsp_pkg.sv
// Purpose: Shared types and constants of the host serial/parallel register port
// Assumes: 16-bit register map of 128 entries, read combinationally by address
// Notes: Pin groups travel as packed structs
// Summary of operation
// - Two static select pins choose serial or one of three parallel modes.
// - Serial mode: chip select frames, write strobe clocks, read strobe is data in.
// - Serial clock, asynchronous to system, is sampled by the 20 MHz system clock, so must run far below it.
// - Chip select high resets serial logic except address and receive data registers.
// - Serial input sampled on falling edges, output updated on rising edges.
// - One serial word transfer takes 24 serial clocks.
// - First frame bit selects direction: high read, low write.
// - Seven address bits MSB first, then sixteen data bits MSB first.
// - Eighth falling edge captures address bit 0 and fetches the register.
// - Ninth rising edge loads fetched word, shifted out MSB first, also on writes.
// - Twenty-fourth falling edge takes last bit and writes the map on writes.
// - Continued frames increment the address per word, wrapping 7Fh to 0.
// - Chip select rising before a word's 16th clock discards that word.
// - Parallel cycles act only with chip select low; modes 1/2 read on low strobe.
// - Modes 1 and 2 capture write data on write strobe rising edge.
// - Mode 2 latches the address when address latch enable falls.
// - Mode 3 write pin is direction; high with strobe low drives read data.
// - Mode 3 write is strobe pulse with direction low, captured on rising edge.
// - Mode 3 latches the address when address valid rises.
// - Parallel address write sets pointer, incremented after every later two-byte word.
package hsp_pkg;

    localparam int HSP_ADDR_W = 7;
    localparam int HSP_DATA_W = 16;
    localparam int HSP_BUS_W = 8;
    localparam int HSP_CNT_W = 4;
    localparam int HSP_CLK_HZ = 20_000_000;
    localparam int HSP_SCLK_MAX_HZ = 40_000_000;
    localparam int HSP_SCLK_OPT2_HZ = 25_000_000;
    localparam logic [HSP_CNT_W-1:0] HSP_HDR_BITS = 4'h8;
    localparam logic [HSP_CNT_W-1:0] HSP_ADDR_LAST = 4'h7;
    localparam logic [HSP_CNT_W-1:0] HSP_DATA_LAST = 4'hF;
    localparam logic [HSP_ADDR_W-1:0] HSP_ADDR_RST = 7'h00;
    localparam logic [HSP_DATA_W-1:0] HSP_DATA_RST = 16'h0000;
    localparam logic [HSP_BUS_W-1:0] HSP_BUS_RST = 8'h00;
    localparam logic [HSP_BUS_W-1:0] HSP_BUS_ALL = 8'hFF;
    localparam logic [HSP_BUS_W-1:0] HSP_BUS_BIT0 = 8'h01;

    typedef enum logic [1:0] {
        HSP_SERIAL = 2'b00,
        HSP_PAR1 = 2'b01,
        HSP_PAR2 = 2'b10,
        HSP_PAR3 = 2'b11
    } hsp_mode_t;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic ale;
        logic sel_hi;
        logic sel_lo;
        logic [HSP_BUS_W-1:0] bus;
    } hsp_pins_t;

    localparam int HSP_PIN_W = $bits(hsp_pins_t);

    typedef struct packed {
        logic [HSP_ADDR_W-1:0] addr;
        logic [HSP_DATA_W-1:0] wdata;
        logic wr;
    } hsp_map_req_t;

endpackage

// >>> design/hsp_port.sv
// Purpose: Host serial/parallel port into a 16-bit register map
// Assumes: map_rdata is a combinational read of map_req.addr; serial clock far below clk
// Notes: Parallel words move as two bytes, high byte first
`timescale 1ns/1ps
module hsp_port
    import hsp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic ale,
    input wire logic interface_select_hi,
    input wire logic interface_select_lo,
    input wire logic [HSP_BUS_W-1:0] bus_in,
    output logic [HSP_BUS_W-1:0] bus_out,
    output logic [HSP_BUS_W-1:0] bus_oe,
    output hsp_map_req_t map_req,
    input wire logic [HSP_DATA_W-1:0] map_rdata
);
    hsp_pins_t pin_raw;
    hsp_pins_t pin;
    hsp_pins_t pin_q;
    hsp_mode_t mode;

    logic [HSP_ADDR_W-1:0] ptr;
    logic [HSP_DATA_W-1:0] word;
    logic [1:0] fetch_d;
    logic [HSP_ADDR_W-1:0] map_addr;
    logic [HSP_DATA_W-1:0] map_wdata;
    logic map_wr;

    logic [HSP_CNT_W-1:0] hdr_cnt;
    logic [HSP_CNT_W-1:0] dat_cnt;
    logic [HSP_CNT_W-1:0] rise_hdr;
    logic [HSP_CNT_W-1:0] rise_dat;
    logic is_read;
    logic [HSP_DATA_W-1:0] sin;
    logic [HSP_DATA_W-1:0] sout;

    logic byte_lo;
    logic [HSP_BUS_W-1:0] hold_hi;

    logic serial;
    logic sel;
    logic wr_rise;
    logic wr_fall;
    logic rd_rise;
    logic ale_rise;
    logic ale_fall;
    logic ser_fall;
    logic ser_rise;
    logic ser_hdr_bit;
    logic ser_word_end;
    logic par_addr;
    logic par_wr;
    logic par_rd_done;
    logic par_word_done;
    logic par_drive;

    assign pin_raw = {cs_n, wr_n, rd_n, ale, interface_select_hi, interface_select_lo, bus_in};
    assign map_req = '{addr: map_addr, wdata: map_wdata, wr: map_wr};

    // Strobes and chip select rest high, address select low, so no edge follows reset
    hsp_sync #(
        .W(HSP_PIN_W),
        .RST_VAL({4'hE, 2'b00, HSP_BUS_RST})
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .din(pin_raw),
        .dout(pin)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q <= {4'hE, 2'b00, HSP_BUS_RST};
        end else begin
            pin_q <= pin;
        end
    end

    // Static mode pins pick the interface
    assign mode = hsp_mode_t'({pin.sel_hi, pin.sel_lo});
    assign serial = (mode == HSP_SERIAL);
    assign sel = ~pin.cs_n;

    assign wr_rise = pin.wr_n & ~pin_q.wr_n;
    assign wr_fall = ~pin.wr_n & pin_q.wr_n;
    assign rd_rise = pin.rd_n & ~pin_q.rd_n;
    assign ale_rise = pin.ale & ~pin_q.ale;
    assign ale_fall = ~pin.ale & pin_q.ale;

    // Serial clock edges count only inside a frame; the serial clock is sampled by clk
    assign ser_fall = serial & sel & wr_fall;
    assign ser_rise = serial & sel & wr_rise;
    assign ser_hdr_bit = ser_fall & (hdr_cnt != 4'h0) & (hdr_cnt < HSP_HDR_BITS);
    assign ser_word_end = ser_fall & (hdr_cnt == HSP_HDR_BITS) & (dat_cnt == HSP_DATA_LAST);

    // Parallel strobe decode per mode, all qualified by chip select
    always_comb begin
        par_addr = 1'b0;
        par_wr = 1'b0;
        par_rd_done = 1'b0;
        par_drive = 1'b0;
        case (mode)
            HSP_PAR1: begin
                par_addr = sel & wr_rise & pin.ale;
                par_wr = sel & wr_rise & ~pin.ale;
                par_rd_done = sel & rd_rise;
                par_drive = sel & ~pin.rd_n;
            end
            HSP_PAR2: begin
                par_addr = sel & ale_fall;
                par_wr = sel & wr_rise;
                par_rd_done = sel & rd_rise;
                par_drive = sel & ~pin.rd_n;
            end
            HSP_PAR3: begin
                par_addr = sel & ale_rise;
                par_wr = sel & rd_rise & ~pin.wr_n;
                par_rd_done = sel & rd_rise & pin.wr_n;
                par_drive = sel & ~pin.rd_n & pin.wr_n;
            end
            default: begin
                par_addr = 1'b0;
            end
        endcase
    end

    assign par_word_done = (par_wr | par_rd_done) & byte_lo & ~par_addr;

    // Address register: serial header shift, word increments, parallel pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr <= HSP_ADDR_RST;
        end else if (ser_hdr_bit) begin
            ptr <= {ptr[HSP_ADDR_W-2:0], pin.rd_n};
        end else if (par_addr) begin
            ptr <= pin.bus[HSP_ADDR_W-1:0];
        end else if (ser_word_end | par_word_done) begin
            ptr <= ptr + 7'h01;
        end
    end

    // Map address lags ptr so a write pulse still sees the word's own address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            map_addr <= HSP_ADDR_RST;
        end else begin
            map_addr <= ptr;
        end
    end

    // Fetch is taken two cycles after the address moved
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_d <= 2'b00;
            word <= HSP_DATA_RST;
        end else begin
            fetch_d <= {fetch_d[0], (ser_fall & (hdr_cnt == HSP_ADDR_LAST)) | ser_word_end
                        | par_addr | par_word_done};
            if (fetch_d[1]) begin
                word <= map_rdata;
            end
        end
    end

    // Serial receive side, sampled on falling edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hdr_cnt <= 4'h0;
            dat_cnt <= 4'h0;
            is_read <= 1'b0;
        end else if (pin.cs_n || !serial) begin
            hdr_cnt <= 4'h0;
            dat_cnt <= 4'h0;
            is_read <= 1'b0;
        end else if (ser_fall) begin
            if (hdr_cnt == 4'h0) begin
                is_read <= pin.rd_n;
                hdr_cnt <= hdr_cnt + 4'h1;
            end else if (hdr_cnt < HSP_HDR_BITS) begin
                hdr_cnt <= hdr_cnt + 4'h1;
            end else begin
                dat_cnt <= dat_cnt + 4'h1;
            end
        end
    end

    // Data register keeps its contents across chip select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sin <= HSP_DATA_RST;
        end else if (ser_fall && hdr_cnt == HSP_HDR_BITS) begin
            sin <= {sin[HSP_DATA_W-2:0], pin.rd_n};
        end
    end

    // Serial transmit side, updated on rising edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_hdr <= 4'h0;
            rise_dat <= 4'h0;
            sout <= HSP_DATA_RST;
        end else if (pin.cs_n || !serial) begin
            rise_hdr <= 4'h0;
            rise_dat <= 4'h0;
            sout <= HSP_DATA_RST;
        end else if (ser_rise) begin
            if (rise_hdr < HSP_HDR_BITS) begin
                rise_hdr <= rise_hdr + 4'h1;
            end else begin
                rise_dat <= rise_dat + 4'h1;
                if (rise_dat == 4'h0) begin
                    sout <= word;
                end else begin
                    sout <= {sout[HSP_DATA_W-2:0], 1'b0};
                end
            end
        end
    end

    // Parallel byte pairing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_lo <= 1'b0;
            hold_hi <= HSP_BUS_RST;
        end else if (par_addr) begin
            byte_lo <= 1'b0;
        end else if (par_wr | par_rd_done) begin
            byte_lo <= ~byte_lo;
            if (par_wr && !byte_lo) begin
                hold_hi <= pin.bus;
            end
        end
    end

    // One write pulse per completed word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            map_wr <= 1'b0;
            map_wdata <= HSP_DATA_RST;
        end else begin
            map_wr <= 1'b0;
            if (ser_word_end && !is_read) begin
                map_wr <= 1'b1;
                map_wdata <= {sin[HSP_DATA_W-2:0], pin.rd_n};
            end else if (par_wr && byte_lo && !par_addr) begin
                map_wr <= 1'b1;
                map_wdata <= {hold_hi, pin.bus};
            end
        end
    end

    // Bus drive: serial bit 0 for the whole frame, parallel only while read data is returned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_out <= HSP_BUS_RST;
            bus_oe <= HSP_BUS_RST;
        end else if (serial) begin
            bus_out <= {7'h00, sout[HSP_DATA_W-1]};
            bus_oe <= sel ? HSP_BUS_BIT0 : HSP_BUS_RST;
        end else begin
            bus_out <= byte_lo ? word[HSP_BUS_W-1:0] : word[HSP_DATA_W-1:HSP_BUS_W];
            bus_oe <= par_drive ? HSP_BUS_ALL : HSP_BUS_RST;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_load_word;
        ser_rise && rise_hdr == HSP_HDR_BITS && rise_dat == 4'h0;
    endsequence

    sequence s_shift_out;
        sout == $past(word) ##1 bus_out[0] == $past(sout[HSP_DATA_W-1]);
    endsequence

    chk_idle_hiz: assert property (pin.cs_n |=> bus_oe == HSP_BUS_RST)
        else $error("bus driven while chip select high");

    chk_cs_reset: assert property (pin.cs_n |=> hdr_cnt == 4'h0 && rise_hdr == 4'h0)
        else $error("serial counters not reset by chip select");

    chk_ser_write: assert property (ser_word_end && !is_read |=> map_req.wr
        && map_req.wdata[0] == $past(pin.rd_n) && map_req.addr == $past(ptr))
        else $error("serial write pulse missing or wrong");

    chk_ser_noread_wr: assert property (ser_word_end && is_read |=> !map_req.wr)
        else $error("read frame wrote the map");

    chk_addr_wrap: assert property (ser_word_end && ptr == 7'h7F |=> ptr == HSP_ADDR_RST)
        else $error("address did not wrap");

    chk_fetch_addr: assert property (ser_fall && hdr_cnt == HSP_ADDR_LAST
        |=> ##1 map_req.addr == ptr ##1 word == $past(map_rdata))
        else $error("fetch did not follow address capture");

    chk_load_msb: assert property (s_load_word |=> s_shift_out)
        else $error("output shifter not loaded with fetched word");

    chk_fall_sample: assert property (ser_fall && hdr_cnt == HSP_HDR_BITS
        |=> sin[0] == $past(pin.rd_n))
        else $error("serial input not sampled on falling edge");

    chk_par_read: assert property ((mode == HSP_PAR1 || mode == HSP_PAR2)
        && sel && !pin.rd_n |=> bus_oe == HSP_BUS_ALL)
        else $error("parallel read not driven");

    chk_m3_dir: assert property (mode == HSP_PAR3 && !pin.wr_n |=> bus_oe == HSP_BUS_RST)
        else $error("mode 3 drove bus during write direction");

    chk_par_addr: assert property (par_addr |=> ptr == $past(pin.bus[HSP_ADDR_W-1:0])
        && !byte_lo)
        else $error("parallel address not latched");

    chk_par_incr: assert property (par_word_done |=> ptr == 7'($past(ptr) + 7'h01))
        else $error("pointer did not advance after access");

    chk_par_wdata: assert property (par_wr && byte_lo && !par_addr
        |=> map_req.wr && map_req.wdata[HSP_BUS_W-1:0] == $past(pin.bus))
        else $error("parallel write data not captured");

    // Frame and strobe gating
    chk_ser_drive: assert property (serial && sel |=> bus_oe == HSP_BUS_BIT0)
        else $error("serial data out not driven in frame");

    chk_cs_nowr: assert property (pin.cs_n |=> !map_req.wr)
        else $error("map written while chip select high");

    chk_rd_release: assert property (!serial && pin.rd_n |=> bus_oe == HSP_BUS_RST)
        else $error("bus driven without read strobe");

    chk_m3_latch: assert property (mode == HSP_PAR3 && sel && ale_rise
        |=> ptr == $past(pin.bus[HSP_ADDR_W-1:0]))
        else $error("mode 3 address not latched");

    chk_m3_write: assert property (mode == HSP_PAR3 && sel && rd_rise && !pin.wr_n
        && byte_lo && !ale_rise
        |=> map_req.wr && map_req.wdata[HSP_BUS_W-1:0] == $past(pin.bus))
        else $error("mode 3 write not captured");
endmodule

// >>> design/hsp_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs arrive from outside the clk domain
// Notes: Output follows once the second and third stages agree
`timescale 1ns/1ps
module hsp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per bit, a change is taken only when two stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= RST_VAL;
        end else begin
            dout <= (s2 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
        end
    end
endmodule

// >>> verification/hsp_host_model.sv
// Purpose: Host model that drives the port pins in serial and parallel modes
// Assumes: Caller sets cs_n for parallel cycles; clk is the system clock
// Notes: Pins move 1 ns after a clk edge; the serial clock period is 8 clk
`timescale 1ns/1ps
module hsp_host_model
    import hsp_pkg::*;
(
    input wire logic clk,
    input wire logic [HSP_BUS_W-1:0] bus,
    input wire logic [HSP_BUS_W-1:0] dev_oe,
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    output logic ale,
    output logic [HSP_BUS_W-1:0] drv,
    output logic drv_oe
);
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        ale = 1'b0;
        drv = HSP_BUS_RST;
        drv_oe = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Frame of n serial clocks; rx gathers one bit per rising edge, last one in rx[0]
    task automatic ser_xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
        logic [39:0] sh;
        sh = tx;
        rx = '0;
        cs_n = 1'b0;
        rd_n = sh[39];
        cyc(4);
        for (int i = 0; i < n; i++) begin
            wr_n = 1'b0;
            // Sampled late in the low phase to cover the input synchroniser
            cyc(3);
            rx = {rx[38:0], bus[0]};
            cyc(1);
            wr_n = 1'b1;
            sh = sh << 1;
            rd_n = sh[39];
            cyc(4);
        end
        cyc(3);
        rx = {rx[38:0], bus[0]};
        cyc(1);
        cs_n = 1'b1;
        rd_n = 1'b1;
        cyc(8);
    endtask

    task automatic ser_noise(input int n);
        for (int i = 0; i < n; i++) begin
            wr_n = 1'b0;
            rd_n = 1'b0;
            cyc(4);
            wr_n = 1'b1;
            rd_n = 1'b1;
            cyc(4);
        end
    endtask

    task automatic par_addr(input logic [1:0] m, input logic [6:0] a);
        drv = {1'b0, a};
        drv_oe = 1'b1;
        ale = 1'b1;
        cyc(2);
        if (m == 2'b01) begin
            wr_n = 1'b0;
            cyc(6);
            wr_n = 1'b1;
        end else begin
            cyc(4);
        end
        cyc(2);
        ale = 1'b0;
        cyc(2);
        drv_oe = 1'b0;
        cyc(6);
    endtask

    task automatic par_wr(input logic [1:0] m, input logic [7:0] d);
        drv = d;
        drv_oe = 1'b1;
        if (m == 2'b11) begin
            wr_n = 1'b0;
            cyc(2);
            rd_n = 1'b0;
            cyc(6);
            rd_n = 1'b1;
            cyc(2);
            wr_n = 1'b1;
        end else begin
            cyc(2);
            wr_n = 1'b0;
            cyc(6);
            wr_n = 1'b1;
            cyc(2);
        end
        drv_oe = 1'b0;
        cyc(6);
    endtask

    task automatic par_rd(input logic [1:0] m, output logic [7:0] d, output logic [7:0] o);
        rd_n = 1'b0;
        cyc(6);
        d = bus;
        o = dev_oe;
        rd_n = 1'b1;
        cyc(8);
    endtask
endmodule

// >>> verification/hsp_port_tb.sv
// Purpose: Self-checking bench for the host serial/parallel register port
// Assumes: Register map modelled here with a combinational read
// Notes: Undriven bus bits show a pattern that moves every cycle
`timescale 1ns/1ps
module hsp_port_tb;
    import hsp_pkg::*;
    logic clk;
    logic rst;
    logic interface_select_hi;
    logic interface_select_lo;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic ale;
    logic [HSP_BUS_W-1:0] bus_in;
    logic [HSP_BUS_W-1:0] bus_out;
    logic [HSP_BUS_W-1:0] bus_oe;
    logic [HSP_BUS_W-1:0] h_drv;
    logic h_oe;
    logic [HSP_BUS_W-1:0] idle_pat = 8'h00;
    hsp_map_req_t map_req;
    logic [HSP_DATA_W-1:0] map_rdata;
    logic [HSP_DATA_W-1:0] regs [128];
    int wr_count = 0;
    int num_errors;
    int checks_done;

    hsp_port uut (.clk(clk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .ale(ale),
        .interface_select_hi(interface_select_hi), .interface_select_lo(interface_select_lo),
        .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .map_req(map_req),
        .map_rdata(map_rdata));
    hsp_host_model host (.clk(clk), .bus(bus_in), .dev_oe(bus_oe), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .ale(ale), .drv(h_drv), .drv_oe(h_oe));

    assign bus_in = (bus_oe & bus_out) | (~bus_oe & (h_oe ? h_drv : idle_pat));
    assign map_rdata = regs[map_req.addr];

    always @(posedge clk) begin
        idle_pat <= idle_pat + 8'h3B;
        if (map_req.wr === 1'b1) begin
            regs[map_req.addr] <= map_req.wdata;
            wr_count <= wr_count + 1;
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] m);
        @(posedge clk);
        #1;
        rst = 1'b1;
        {interface_select_hi, interface_select_lo} = m;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        host.cyc(2);
    endtask

    task automatic t_serial;
        logic [39:0] rx;
        logic [15:0] o7f;
        logic [15:0] o00;
        int n;
        do_reset(2'b00);
        o7f = regs[127];
        o00 = regs[0];
        host.ser_xfer({1'b0, 7'h7F, 16'hA55A, 16'h1234}, 40, rx);
        chk_word(regs[127], 16'hA55A);
        chk_word(regs[0], 16'h1234);
        chk_word(rx[31:16], o7f);
        chk_word(rx[15:0], o00);
        chk_byte(bus_oe, HSP_BUS_RST);
        n = wr_count;
        host.ser_xfer({1'b1, 7'h7F, 32'h0000_0000}, 40, rx);
        chk_word(rx[31:16], 16'hA55A);
        chk_word(rx[15:0], 16'h1234);
        chk_word(16'(wr_count), 16'(n));
        $display("test serial done");
    endtask

    task automatic t_abort;
        logic [39:0] rx;
        logic [15:0] o11;
        logic [15:0] o05;
        int n;
        n = wr_count;
        o11 = regs[17];
        // Second word stops after 12 of its 16 clocks
        host.ser_xfer({1'b0, 7'h10, 16'hBEEF, 16'hF00D}, 36, rx);
        chk_word(regs[16], 16'hBEEF);
        chk_word(regs[17], o11);
        chk_word(16'(wr_count), 16'(n + 1));
        host.ser_noise(30);
        chk_word(16'(wr_count), 16'(n + 1));
        chk_byte(bus_oe, HSP_BUS_RST);
        // Fast-host style frame: one extra clock, last bit read a half cycle later
        o05 = regs[5];
        host.ser_xfer({1'b0, 7'h05, 16'h0F0F, 16'h0000}, 25, rx);
        chk_word(rx[16:1], o05);
        chk_word(regs[5], 16'h0F0F);
        chk_word(16'(wr_count), 16'(n + 2));
        $display("test serial abort done");
    endtask

    task automatic t_par(input logic [1:0] m);
        logic [6:0] a;
        logic [31:0] ww;
        logic [7:0] d;
        logic [7:0] o;
        int n;
        a = {m, 5'h0A};
        ww = {16'hC31C + 16'(m), 16'h5AA5 - 16'(m)};
        do_reset(m);
        host.cs_n = 1'b0;
        host.par_addr(m, a);
        for (int k = 0; k < 4; k++) host.par_wr(m, ww[31-8*k -: 8]);
        chk_word(regs[a], ww[31:16]);
        chk_word(regs[a+7'h01], ww[15:0]);
        host.par_addr(m, a);
        for (int k = 0; k < 4; k++) begin
            host.par_rd(m, d, o);
            chk_byte(d, ww[31-8*k -: 8]);
            chk_byte(o, HSP_BUS_ALL);
        end
        chk_byte(bus_oe, HSP_BUS_RST);
        host.cs_n = 1'b1;
        n = wr_count;
        host.par_addr(m, a);
        host.par_wr(m, 8'h99);
        host.par_wr(m, 8'h66);
        host.par_rd(m, d, o);
        chk_byte(o, HSP_BUS_RST);
        chk_word(16'(wr_count), 16'(n));
        $display("test parallel mode %0d done", m);
    endtask

    initial begin
        rst = 1'b1;
        interface_select_hi = 1'b0;
        interface_select_lo = 1'b0;
        num_errors = 0;
        checks_done = 0;
        for (int i = 0; i < 128; i++) regs[i] = 16'(i) * 16'h0203;
        t_serial;
        t_abort;
        for (int m = 1; m < 4; m++) t_par(2'(m));
        test_done;
    end

    initial begin
        repeat (90000) @(posedge clk);
        $display("Run limit reached");
        num_errors++;
        test_done;
    end
endmodule
